// file: ebs_pkg.sv
/*
  Constants and types for the external bus strobe controller.
  Assumes the clock is the oscillator clock itself, one phase tick per edge.
*/
package ebs_pkg;

  // ----------------------------------------------------------------
  // machine cycle phase counter
  // ----------------------------------------------------------------
  localparam int unsigned PH_W         = 4;
  localparam logic [3:0]  PH_RESET     = 4'h0;
  localparam logic [3:0]  PH_LAST_X12  = 4'hB;
  localparam logic [3:0]  PH_LAST_X6   = 4'hA;
  localparam logic [3:0]  PH_STEP_X12  = 4'h1;
  localparam logic [3:0]  PH_STEP_X6   = 4'h2;
  localparam logic        MODE_RESET   = 1'b0;

  // ----------------------------------------------------------------
  // strobe windows, in phase units of a 12-clock machine cycle
  // ----------------------------------------------------------------
  localparam logic [3:0]  ALE1_FIRST   = 4'h0;
  localparam logic [3:0]  ALE1_LAST    = 4'h1;
  localparam logic [3:0]  ALE2_FIRST   = 4'h6;
  localparam logic [3:0]  ALE2_LAST    = 4'h7;
  localparam logic [3:0]  FETCH1_FIRST = 4'h3;
  localparam logic [3:0]  FETCH1_LAST  = 4'h5;
  localparam logic [3:0]  FETCH2_FIRST = 4'h9;
  localparam logic [3:0]  FETCH2_LAST  = 4'hB;
  localparam logic [3:0]  XSTB_FIRST   = 4'h2;
  localparam logic [3:0]  XSTB_LAST    = 4'hA;

  // ----------------------------------------------------------------
  // reset pin qualification
  // ----------------------------------------------------------------
  localparam int unsigned MC_CLOCKS_X12 = 12;
  localparam int unsigned MC_CLOCKS_X6  = 6;
  localparam int unsigned RESET_MC      = 2;
  localparam int unsigned RST_W         = 5;
  localparam logic [4:0]  RST_HOLD_X12  = 5'(RESET_MC * MC_CLOCKS_X12);
  localparam logic [4:0]  RST_HOLD_X6   = 5'(RESET_MC * MC_CLOCKS_X6);
  localparam logic [4:0]  RST_CNT_RESET = 5'h00;

  // ----------------------------------------------------------------
  // port 3 strobe positions and idle levels
  // ----------------------------------------------------------------
  localparam int unsigned P3_RD_BIT   = 7;
  localparam int unsigned P3_WR_BIT   = 6;
  localparam logic [7:0]  P3_RESET    = 8'hFF;
  localparam logic        FETCH_IDLE  = 1'b1;
  localparam logic        ALE_IDLE    = 1'b0;
  localparam logic        STRAP_RESET = 1'b0;

  typedef enum logic [0:0] {
    EBS_CYC_FETCH = 1'b0,
    EBS_CYC_DATA  = 1'b1
  } ebs_cyc_t;

endpackage

// file: ebs_phase_if.sv
/*
  Phase bundle from the machine cycle generator to the strobe logic.
  Assumes one driver (gen) and one reader (sink), both on the same clock.
*/
`timescale 1ns/100ps
interface ebs_phase_if;
  logic [3:0] phase;
  logic       cyc_end;
  logic       six_clk;

  modport gen  (output phase, output cyc_end, output six_clk);
  modport sink (input phase, input cyc_end, input six_clk);
endinterface

// file: ebs_phase_gen.sv
/*
  Machine cycle phase generator: twelve or six clocks per machine cycle.
  Assumes a synchronised active low reset and a mode input that may change any time.
*/
`timescale 1ns/100ps
module ebs_phase_gen (
  input  wire logic   clk_i,
  input  wire logic   rst_ni,
  input  wire logic   six_clock_mode_i,
  ebs_phase_if.gen    ph_if
);
  import ebs_pkg::*;

  logic [3:0] phase_q;
  logic [3:0] phase_d;
  logic       mode_q;
  wire        last_w = mode_q ? (phase_q == PH_LAST_X6) : (phase_q == PH_LAST_X12);
  wire  [3:0] step_w = mode_q ? PH_STEP_X6 : PH_STEP_X12;

  // six-clock mode steps by two so both modes share one phase decode
  assign phase_d = last_w ? PH_RESET : 4'(phase_q + step_w);

  // mode is only taken at a cycle boundary so the count never lands off-grid
  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      phase_q <= PH_RESET;
      mode_q  <= MODE_RESET;
    end else begin
      phase_q <= phase_d;
      if (last_w) begin
        mode_q <= six_clock_mode_i;
      end
    end
  end

  assign ph_if.phase   = phase_q;
  assign ph_if.cyc_end = last_w;
  assign ph_if.six_clk = mode_q;
endmodule

// file: ebs_strobe_ctrl.sv
/*
  External bus strobe controller: fetch strobe, address latch pulse,
  data read/write strobes on port 3, reset pin qualification and fetch strap.
  Assumes clock_i is the oscillator clock and all pin inputs are synchronous to it.
*/
// What this block does
// - fetch strobe stays high while code runs from on-chip memory
// - external fetch: fetch strobe pulses low twice per machine cycle
// - each external data access drops two consecutive fetch strobe pulses
// - reset pin high for two machine cycles resets the device
// - strap low selects external code fetch, high selects on-chip fetch
// - address latch pulse marks the low address byte on the shared bus
// - twelve-clock mode: latch pulse runs continuously at crystal over six
// - six-clock mode: latch pulse runs at crystal over three
// - each external data access drops exactly one latch pulse
// - latch strobe off bit set to one suppresses the latch output
// - port 3 bit 7 is data read strobe, bit 6 data write strobe
`timescale 1ns/100ps
module ebs_strobe_ctrl (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       reset_pin_i,
  input  wire logic       external_fetch_select_n_i,
  input  wire logic       six_clock_mode_i,
  input  wire logic       latch_strobe_off_i,
  input  wire logic       xdata_req_i,
  input  wire logic       xdata_we_i,
  input  wire logic [7:0] p3_latch_i,
  output logic            program_fetch_strobe_n_o,
  output logic            address_latch_o,
  output logic      [7:0] p3_pin_o,
  output logic            xdata_ack_o,
  output logic            device_reset_o,
  output logic            fetch_external_o
);
  import ebs_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta_q;
  logic rst_sync_q;

  // entry into reset is immediate; leaving it waits two edges so that no flop
  // below sees the release close to a clock edge

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // machine cycle phase
  // ----------------------------------------------------------------
  // the generator owns the cycle count; everything here only decodes its phase
  ebs_phase_if ph_if ();

  ebs_phase_gen u_phase (
    .clk_i            (clock_i),
    .rst_ni           (rst_sync_q),
    .six_clock_mode_i (six_clock_mode_i),
    .ph_if            (ph_if)
  );

  wire [3:0] phase_w = ph_if.phase;
  wire       cyc_end = ph_if.cyc_end;

  // ----------------------------------------------------------------
  // reset pin qualification
  // ----------------------------------------------------------------
  logic [4:0] rst_cnt_q;
  logic [4:0] rst_cnt_d;
  logic       pin_rst_q;

  // hold target follows the generator mode latched at a cycle boundary; the count saturates, and the at-or-above
  // compare keeps a drop to the shorter target mid-hold from being skipped
  wire  [4:0] rst_hold_w = ph_if.six_clk ? RST_HOLD_X6 : RST_HOLD_X12;
  wire        rst_full_w = (rst_cnt_q >= rst_hold_w);

  assign rst_cnt_d = !reset_pin_i ? RST_CNT_RESET :
                     rst_full_w   ? rst_cnt_q     : 5'(rst_cnt_q + 5'h01);

  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      rst_cnt_q <= RST_CNT_RESET;
      pin_rst_q <= 1'b0;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      pin_rst_q <= reset_pin_i & rst_full_w;
    end
  end

  assign device_reset_o = pin_rst_q;

  // ----------------------------------------------------------------
  // fetch source strap
  // ----------------------------------------------------------------
  logic strap_taken_q;
  logic fetch_ext_q;

  // the strap is a board tie, so one capture per reset is enough
  // caught after release and again throughout every pin reset
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      strap_taken_q <= 1'b0;
      fetch_ext_q   <= STRAP_RESET;
    end else begin
      strap_taken_q <= 1'b1;
      if (!strap_taken_q || pin_rst_q) begin
        fetch_ext_q <= !external_fetch_select_n_i;
      end
    end
  end

  assign fetch_external_o = fetch_ext_q;

  // ----------------------------------------------------------------
  // cycle type: a data access owns the whole following machine cycle
  // ----------------------------------------------------------------
  ebs_cyc_t cyc_q;
  ebs_cyc_t cyc_d;
  logic     we_q;

  // a request waits for the last phase; none is taken while the pin holds reset
  wire take_w = cyc_end & xdata_req_i & !pin_rst_q;

  always_comb begin
    cyc_d = cyc_q;
    case (cyc_q)
      EBS_CYC_FETCH: begin
        if (take_w) begin
          cyc_d = EBS_CYC_DATA;
        end
      end
      EBS_CYC_DATA: begin
        if (pin_rst_q) begin
          cyc_d = EBS_CYC_FETCH;
        end else if (cyc_end) begin
          cyc_d = take_w ? EBS_CYC_DATA : EBS_CYC_FETCH;
        end
      end
      default: begin
        cyc_d = EBS_CYC_FETCH;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cyc_q <= EBS_CYC_FETCH;
      we_q  <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      if (take_w) begin
        we_q <= xdata_we_i;
      end
    end
  end

  wire data_cyc_w = (cyc_q == EBS_CYC_DATA) & !pin_rst_q;

  // handshake only: combinational, high on the final clock of the data cycle
  assign xdata_ack_o = data_cyc_w & cyc_end;

  // ----------------------------------------------------------------
  // strobe decode
  // ----------------------------------------------------------------
  wire ale1_w   = (phase_w >= ALE1_FIRST) & (phase_w <= ALE1_LAST);
  wire ale2_w   = (phase_w >= ALE2_FIRST) & (phase_w <= ALE2_LAST);
  wire fetch1_w = (phase_w >= FETCH1_FIRST) & (phase_w <= FETCH1_LAST);
  wire fetch2_w = (phase_w >= FETCH2_FIRST) & (phase_w <= FETCH2_LAST);
  wire xstb_w   = (phase_w >= XSTB_FIRST) & (phase_w <= XSTB_LAST);

  // two pulses per cycle give crystal/6, or crystal/3 with the double step
  // the data cycle loses its first pulse only; its second latches the next fetch
  wire ale_w    = (ale1_w & !data_cyc_w) | ale2_w;
  wire ale_en_w = ale_w & !latch_strobe_off_i & !pin_rst_q;

  // both fetch pulses of the data cycle are dropped, back to back
  wire fetch_w  = fetch_ext_q & !data_cyc_w & !pin_rst_q
                & (fetch1_w | fetch2_w);

  // data strobes run whatever the fetch source; their window never meets a fetch
  wire rd_w     = data_cyc_w & !we_q & xstb_w;
  wire wr_w     = data_cyc_w & we_q & xstb_w;

  logic [7:0] p3_d;

  // only bits 7 and 6 are overridden; the rest follow the port latch
  always_comb begin
    p3_d            = p3_latch_i;
    p3_d[P3_RD_BIT] = p3_latch_i[P3_RD_BIT] & !rd_w;
    p3_d[P3_WR_BIT] = p3_latch_i[P3_WR_BIT] & !wr_w;
  end

  // ----------------------------------------------------------------
  // output registers: one clock behind the phase decode
  // ----------------------------------------------------------------
  // registering every pin keeps decode glitches off the external bus
  always_ff @(posedge clock_i or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      program_fetch_strobe_n_o <= FETCH_IDLE;
      address_latch_o          <= ALE_IDLE;
      p3_pin_o                 <= P3_RESET;
    end else begin
      program_fetch_strobe_n_o <= !fetch_w;
      address_latch_o          <= ale_en_w;
      p3_pin_o                 <= p3_d;
    end
  end
endmodule

// file: ebs_strobe_ctrl_asserts.sv
/* Port-level checks of the strobe controller.
   Bound from the bench top; mode is expected to change only while running. */
`timescale 1ns/100ps
module ebs_strobe_ctrl_asserts (
  input wire logic       clock_i,
  input wire logic       resetn_i,
  input wire logic       reset_pin_i,
  input wire logic       six_clock_mode_i,
  input wire logic       latch_strobe_off_i,
  input wire logic       program_fetch_strobe_n_o,
  input wire logic       address_latch_o,
  input wire logic [7:0] p3_pin_o,
  input wire logic       xdata_ack_o,
  input wire logic       device_reset_o,
  input wire logic       fetch_external_o
);
  // ----------
  // reset pin hold counter
  // ----------
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  assign hold_d = reset_pin_i ? hold_q + {7'h00, hold_q != 8'hFF} : 8'h00;
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) hold_q <= 8'h00;
    else hold_q <= hold_d;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_latch_x12;
    address_latch_o ##1 !address_latch_o [*4];
  endsequence
  // ----------
  // strobe shape and qualification
  // ----------
  a_fetch_idle_int: assert property (!fetch_external_o && !$past(fetch_external_o) |->
    program_fetch_strobe_n_o) else $error("fetch strobe with on-chip fetch");
  a_latch_off_quiet: assert property (latch_strobe_off_i |=> !address_latch_o)
    else $error("latch pulse while off");
  a_latch_x12_shape: assert property ($rose(address_latch_o) && !six_clock_mode_i
    && !$past(six_clock_mode_i, 12) && !$past(device_reset_o) |=> s_latch_x12)
    else $error("latch shape in 12-clock mode");
  a_latch_x6_shape: assert property ($rose(address_latch_o) && six_clock_mode_i
    && $past(six_clock_mode_i, 12) |=> !address_latch_o [*2]) else $error("latch x6 shape");
  a_fetch_x6_width: assert property ($fell(program_fetch_strobe_n_o) && six_clock_mode_i
    && $past(six_clock_mode_i, 12) |=> program_fetch_strobe_n_o) else $error("fetch x6 width");
  a_fetch_latch_apart: assert property (!program_fetch_strobe_n_o |-> !address_latch_o)
    else $error("fetch and latch overlap");
  a_ack_data_strobe: assert property (xdata_ack_o |-> !(p3_pin_o[7] && p3_pin_o[6]))
    else $error("ack without data strobe");
  a_reset_pin_hold: assert property ($rose(device_reset_o) |->
    hold_q >= (six_clock_mode_i ? 8'h0C : 8'h18)) else $error("pin reset too early");
endmodule

// file: ebs_mem_model.sv
/* Far-side memory with address latch: counts captures and strobes.
   Assumes strobes settle before each oscillator clock edge. */
`timescale 1ns/100ps
module ebs_mem_model (
  input  wire logic       clk_i,
  input  wire logic       latch_i,
  input  wire logic       fetch_n_i,
  input  wire logic [7:0] p3_i,
  output int              latch_cnt_o,
  output int              fetch_cnt_o,
  output int              rd_cnt_o,
  output int              wr_cnt_o
);
  logic       latch_q = 1'b0;
  logic       fetch_q = 1'b1;
  logic [1:0] strb_q  = 2'h3;
  // ----------
  // edge counting
  // ----------
  always @(posedge clk_i) begin
    latch_q <= latch_i;
    fetch_q <= fetch_n_i;
    strb_q  <= p3_i[7:6];
    if (latch_i && !latch_q) latch_cnt_o <= latch_cnt_o + 1;
    if (!fetch_n_i && fetch_q) fetch_cnt_o <= fetch_cnt_o + 1;
    if (!p3_i[7] && strb_q[1]) rd_cnt_o <= rd_cnt_o + 1;
    if (!p3_i[6] && strb_q[0]) wr_cnt_o <= wr_cnt_o + 1;
  end
endmodule

// file: test_ebs_strobe_ctrl.sv
/* Self-checking bench of the strobe controller.
   Assumes the memory model and the checker are compiled first. */
`timescale 1ns/100ps
module test_ebs_strobe_ctrl;
  logic       clk = 1'b0, rstn = 1'b0, pin = 1'b0, strap_n = 1'b1, six = 1'b0;
  logic       loff = 1'b0, req = 1'b0, xwe = 1'b0;
  logic [7:0] p3 = 8'hD5;
  logic [7:0] p3o;
  logic       fetch_n, ale, ack, drst, fext;
  int         lc, fc, rc, wc, bl, bf, br, bw;
  int         n_errors = 0, comparisons = 0, cycles = 0;
  ebs_strobe_ctrl uut (.clock_i(clk), .resetn_i(rstn), .reset_pin_i(pin),
    .external_fetch_select_n_i(strap_n), .six_clock_mode_i(six), .latch_strobe_off_i(loff),
    .xdata_req_i(req), .xdata_we_i(xwe), .p3_latch_i(p3), .program_fetch_strobe_n_o(fetch_n),
    .address_latch_o(ale), .p3_pin_o(p3o), .xdata_ack_o(ack), .device_reset_o(drst),
    .fetch_external_o(fext));
  ebs_mem_model mem (.clk_i(clk), .latch_i(ale), .fetch_n_i(fetch_n), .p3_i(p3o),
    .latch_cnt_o(lc), .fetch_cnt_o(fc), .rd_cnt_o(rc), .wr_cnt_o(wc));
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      results();
    end
  end
  // ----------
  // helpers
  // ----------
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic snap();
    bl = lc; bf = fc; br = rc; bw = wc;
  endtask
  task automatic chk(string name, int exp, int got);
    comparisons++;
    if (exp != got) begin
      n_errors++;
      $display("Error %s expected %0d seen %0d", name, exp, got);
    end
  endtask
  task automatic chk_b(string name, logic exp, logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    cyc(2);
    rstn = 1'b1;
    cyc(6);
  endtask
  task automatic results();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic t_internal();
    strap_n = 1'b1;
    do_reset();
    snap();
    cyc(48);
    chk("latch", 8, lc - bl);
    chk("fetch", 0, fc - bf);
    chk_b("fext", 1'b0, fext);
  endtask
  task automatic t_pin_reset();
    pin = 1'b1;
    cyc(23);
    pin = 1'b0;
    cyc(1);
    chk_b("drst", 1'b0, drst);
    pin = 1'b1;
    cyc(24);
    chk_b("drst", 1'b0, drst);
    cyc(1);
    chk_b("drst", 1'b1, drst);
    snap();
    cyc(12);
    chk("latch", 0, lc - bl);
    pin = 1'b0;
    cyc(1);
    chk_b("drst", 1'b0, drst);
  endtask
  task automatic t_external();
    strap_n = 1'b0;
    do_reset();
    chk_b("fext", 1'b1, fext);
    snap();
    cyc(48);
    chk("latch", 8, lc - bl);
    chk("fetch", 8, fc - bf);
  endtask
  task automatic t_data(logic we, int n);
    int k = 0;
    int acks = 0;
    snap();
    xwe = we;
    req = 1'b1;
    while (acks < n && k < 44) begin
      cyc(1);
      k++;
      if (ack === 1'b1) acks++;
      if (acks == n) req = 1'b0;
    end
    cyc(48 - k);
    chk("acks", n, acks);
    chk("latch", 8 - n, lc - bl);
    chk("fetch", 8 - 2 * n, fc - bf);
    chk("read", we ? 0 : n, rc - br);
    chk("write", we ? n : 0, wc - bw);
    chk_b("p3", 1'b1, p3o[5:0] === p3[5:0]);
  endtask
  task automatic t_latch_off();
    logic p;
    repeat (20) begin
      p = ale;
      cyc(1);
      if (p === 1'b1 && ale === 1'b0) break;
    end
    loff = 1'b1;
    snap();
    cyc(24);
    chk("latch", 0, lc - bl);
    loff = 1'b0;
    snap();
    cyc(48);
    chk("latch", 8, lc - bl);
  endtask
  task automatic t_six();
    six = 1'b1;
    cyc(24);
    snap();
    cyc(48);
    chk("latch", 16, lc - bl);
    chk("fetch", 16, fc - bf);
  endtask
  initial begin
    t_internal();
    t_pin_reset();
    t_external();
    t_data(1'b0, 1);
    t_data(1'b1, 1);
    t_data(1'b0, 2);
    t_latch_off();
    t_six();
    results();
  end
endmodule
bind ebs_strobe_ctrl ebs_strobe_ctrl_asserts u_chk (.clock_i, .resetn_i, .reset_pin_i,
  .six_clock_mode_i, .latch_strobe_off_i, .program_fetch_strobe_n_o, .address_latch_o,
  .p3_pin_o, .xdata_ack_o, .device_reset_o, .fetch_external_o);
